/* rcs_core.sv */
// Function
// RULE_01: oscillator start not tied to startup timers
// RULE_02: monitor on, clock not ready: fail trap
// RULE_03: fail trap switches clock to fast rc
// RULE_04: monitor and timer off: exit reset fast
// RULE_05: rc or external clock active at once
// RULE_06: monitor off, no clock: freeze at vector
// RULE_07: cause flags software readable and writable
// RULE_08: pin reset sets external, clears sw/wdt/idle/sleep
// RULE_09: software reset sets sw, clears others
// RULE_10: pin reset in sleep sets external and sleep
// RULE_11: pin reset in idle sets external and idle
// RULE_12: interrupt wake: pc plus two, sleep set
// RULE_13: enabled interrupt wake loads its vector
// RULE_14: flags untouched by event stay unchanged
// RULE_15: power-on sets only por; watchdog restarts zero
// RULE_16: watchdog wake pc plus two; trap flags
//
// reset cause recorder and start-up sequencer with an APB slave
// assumes event inputs are one-cycle pulses synchronous to pclk
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
module rcs_core #(
  parameter int PUT_CYCLES = rcs_pkg::RCS_PUT_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // events and oscillator status
  input wire rcs_pkg::rcs_evt_t evt,
  input wire rcs_pkg::rcs_osc_t osc,
  input wire logic in_sleep,
  input wire logic in_idle,
  input wire logic [23:0] cur_pc,
  input wire logic [23:0] irq_vector,
  // core side
  output logic core_run,
  output logic restart_pulse,
  output logic [23:0] restart_pc,
  output rcs_pkg::rcs_src_t clk_src,
  output logic irq
);
  import rcs_pkg::*;

  logic [RCS_NFLAG-1:0] cause_q; // reset cause flags
  logic [1:0] ctrl_q; // monitor and timer enables
  rcs_state_t st_q; // start-up state
  logic [RCS_NEV-1:0] ist_q; // sticky interrupt status
  logic [RCS_NEV-1:0] ien_q; // interrupt enables
  logic start_q; // kicks the timer once after reset
  logic timer_done;

  // apb decode
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire a_cause = (paddr == RCS_OFF_CAUSE);
  wire a_ctrl = (paddr == RCS_OFF_CTRL);
  wire a_stat = (paddr == RCS_OFF_STAT);
  wire a_ist = (paddr == RCS_OFF_IRQ_ST);
  wire a_ien = (paddr == RCS_OFF_IRQ_EN);
  wire a_iclr = (paddr == RCS_OFF_IRQ_CLR);
  wire a_pc = (paddr == RCS_OFF_PC);
  wire mapped = a_cause || a_ctrl || a_stat || a_ist || a_ien ||
                a_iclr || a_pc;

  // clock readiness, independent of the timer chain [RULE_01]
  wire clk_ready = osc.osc_running &&
                   (osc.ost_done || clk_src != RCS_SRC_XTAL) &&
                   (osc.pll_lock || !osc.pll_used);
  wire cfm_en = ctrl_q[RCS_C_CFM];
  // fast exit skips the timer when both features are off [RULE_04]
  wire put_bypass = !ctrl_q[RCS_C_PUT] && !cfm_en;
  wire clk_fail = (st_q == RCS_ST_CHECK) && cfm_en && !clk_ready;
  wire go_run = (st_q == RCS_ST_CHECK || st_q == RCS_ST_FROZEN) &&
                clk_ready;

  // flag update per event; unlisted bits keep their value [RULE_14]
  function automatic logic [RCS_NFLAG-1:0] upd(
    input logic [RCS_NFLAG-1:0] f, input logic [RCS_NFLAG-1:0] s,
    input logic [RCS_NFLAG-1:0] c);
    upd = (f & ~c) | s;
  endfunction
  function automatic logic [RCS_NFLAG-1:0] bit1(input int b);
    bit1 = RCS_NFLAG'(1) << b;
  endfunction

  logic [RCS_NFLAG-1:0] ev_set; // flags the event raises
  logic [RCS_NFLAG-1:0] ev_clr; // flags the event drops
  logic [23:0] ev_pc;
  logic ev_any;
  logic ev_wake;
  // event priority: pin, software, watchdog, traps, wake
  always_comb begin
    ev_set = '0;
    ev_clr = '0;
    ev_pc = RCS_VEC_RESET;
    ev_any = 1'b1;
    ev_wake = 1'b0;
    if (evt.pin_rst && in_sleep) begin
      ev_set = bit1(RCS_B_EXTERNAL_RESET_FLAG) | bit1(RCS_B_SLEEP); // [RULE_10]
      ev_clr = bit1(RCS_B_WATCHDOG_TIMEOUT_FLAG) | bit1(RCS_B_IDLE);
    end else if (evt.pin_rst && in_idle) begin
      ev_set = bit1(RCS_B_EXTERNAL_RESET_FLAG) | bit1(RCS_B_IDLE); // [RULE_11]
      ev_clr = bit1(RCS_B_WATCHDOG_TIMEOUT_FLAG) | bit1(RCS_B_SLEEP);
    end else if (evt.pin_rst) begin
      ev_set = bit1(RCS_B_EXTERNAL_RESET_FLAG); // [RULE_08]
      ev_clr = bit1(RCS_B_SWRST) | bit1(RCS_B_WATCHDOG_TIMEOUT_FLAG) |
               bit1(RCS_B_IDLE) | bit1(RCS_B_SLEEP);
    end else if (evt.sw_rst) begin
      ev_set = bit1(RCS_B_SWRST); // [RULE_09]
      ev_clr = bit1(RCS_B_EXTERNAL_RESET_FLAG) | bit1(RCS_B_WATCHDOG_TIMEOUT_FLAG) |
               bit1(RCS_B_IDLE) | bit1(RCS_B_SLEEP);
    end else if (evt.wdt_to && in_sleep) begin
      ev_set = bit1(RCS_B_WATCHDOG_TIMEOUT_FLAG) | bit1(RCS_B_SLEEP); // [RULE_16]
      ev_pc = cur_pc + RCS_PC_STEP;
      ev_wake = 1'b1;
    end else if (evt.wdt_to) begin
      ev_set = bit1(RCS_B_WATCHDOG_TIMEOUT_FLAG); // [RULE_15]
      ev_clr = bit1(RCS_B_EXTERNAL_RESET_FLAG) | bit1(RCS_B_SWRST) |
               bit1(RCS_B_IDLE) | bit1(RCS_B_SLEEP);
    end else if (evt.trap_rst) begin
      ev_set = bit1(RCS_B_TRAP); // [RULE_16]
    end else if (evt.illop_rst) begin
      ev_set = bit1(RCS_B_IOP); // [RULE_16]
    end else if (evt.irq_wake && in_sleep) begin
      ev_set = bit1(RCS_B_SLEEP); // [RULE_12]
      // enabled interrupt jumps to its own vector [RULE_13]
      ev_pc = evt.irq_vec_en ? irq_vector : cur_pc + RCS_PC_STEP;
      ev_wake = 1'b1;
    end else begin
      ev_any = 1'b0;
    end
  end

  // write and event in one cycle: the event's own set and clear bits
  // win, so a cause is never lost to a racing clear [RULE_07]
  wire cause_wr = wr && a_cause;
  wire [RCS_NFLAG-1:0] cause_base =
    cause_wr ? pwdata[RCS_NFLAG-1:0] : cause_q;
  wire [RCS_NFLAG-1:0] cause_d = upd(cause_base, ev_set, ev_clr);

  // cause register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q <= RCS_CAUSE_RST; // power-on sets only por [RULE_15]
    end else begin
      cause_q <= cause_d; // [RULE_07]
    end
  end

  // control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= RCS_CTRL_RST[1:0];
    end else if (wr && a_ctrl) begin
      ctrl_q <= pwdata[RCS_C_PUT:RCS_C_CFM];
    end
  end

  rcs_put_timer #(.CYCLES(PUT_CYCLES)) u_put (
    .pclk(pclk),
    .presetn(presetn),
    .start(start_q),
    .bypass(put_bypass),
    .done(timer_done)
  );

  // start-up sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= RCS_ST_TIMER;
      start_q <= 1'b1;
    end else begin
      start_q <= 1'b0;
      case (st_q)
        RCS_ST_TIMER: begin
          if (timer_done) begin
            st_q <= RCS_ST_CHECK;
          end
        end
        RCS_ST_CHECK: begin
          if (clk_ready || clk_fail) begin
            st_q <= RCS_ST_RUN; // [RULE_02] [RULE_05]
          end else begin
            st_q <= RCS_ST_FROZEN; // held at vector [RULE_06]
          end
        end
        RCS_ST_FROZEN: begin
          if (clk_ready) begin
            st_q <= RCS_ST_RUN; // [RULE_06]
          end
        end
        default: begin
          st_q <= RCS_ST_RUN;
        end
      endcase
    end
  end

  // clock source, forced to fast rc on failure
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_src <= RCS_SRC_XTAL;
    end else if (clk_fail) begin
      clk_src <= RCS_SRC_FRC; // [RULE_03]
    end else if (wr && a_ctrl) begin
      clk_src <= rcs_src_t'(pwdata[RCS_C_SRC +: 2]); // handler choice
    end
  end

  // restart outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_run <= 1'b0;
      restart_pulse <= 1'b0;
      restart_pc <= RCS_VEC_RESET;
    end else begin
      restart_pulse <= clk_fail || go_run || (ev_any && st_q == RCS_ST_RUN);
      if (clk_fail) begin
        restart_pc <= RCS_VEC_CLKFAIL; // [RULE_02]
        core_run <= 1'b1;
      end else if (go_run) begin
        restart_pc <= RCS_VEC_RESET; // [RULE_04]
        core_run <= 1'b1;
      end else if (ev_any && st_q == RCS_ST_RUN) begin
        restart_pc <= ev_pc; // [RULE_08] [RULE_12]
      end
    end
  end

  // interrupt status: set beats clear
  wire [RCS_NEV-1:0] ev_vec = {ev_wake, ev_any && !ev_wake, clk_fail};
  wire [RCS_NEV-1:0] iclr = (wr && a_iclr) ? pwdata[RCS_NEV-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= '0;
      ien_q <= '0;
      irq <= 1'b0;
    end else begin
      ist_q <= (ist_q & ~iclr) | ev_vec;
      if (wr && a_ien) begin
        ien_q <= pwdata[RCS_NEV-1:0];
      end
      irq <= |(((ist_q & ~iclr) | ev_vec) & ien_q);
    end
  end

  // apb read mux, zero wait states
  wire [31:0] rdat =
    a_cause ? 32'(cause_q) :
    a_ctrl ? 32'({clk_src, ctrl_q[1:0]}) :
    a_stat ? 32'({clk_ready, st_q}) :
    a_ist ? 32'(ist_q) :
    a_ien ? 32'(ien_q) :
    a_pc ? 32'(restart_pc) : 32'h00000000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? rdat : 32'h00000000;
    end
  end

  // assertions
  fail_vector_a: assert property ( // [RULE_02]
    @(posedge pclk) disable iff (!presetn)
    clk_fail |=> restart_pc == RCS_VEC_CLKFAIL && core_run)
    else $error("clock fail did not load trap vector");
  fail_src_a: assert property ( // [RULE_03]
    @(posedge pclk) disable iff (!presetn)
    clk_fail |=> clk_src == RCS_SRC_FRC)
    else $error("clock fail did not select fast rc");
  frozen_hold_a: assert property ( // [RULE_06]
    @(posedge pclk) disable iff (!presetn)
    st_q == RCS_ST_FROZEN && !clk_ready |=> !core_run)
    else $error("core ran without a clock");
  freeze_entry_a: assert property ( // [RULE_06]
    @(posedge pclk) disable iff (!presetn)
    st_q == RCS_ST_CHECK && !cfm_en && !clk_ready |=>
      st_q == RCS_ST_FROZEN)
    else $error("missing clock did not freeze start-up");
  fast_exit_a: assert property ( // [RULE_04]
    @(posedge pclk) disable iff (!presetn)
    st_q == RCS_ST_TIMER && put_bypass |-> ##2 st_q != RCS_ST_TIMER)
    else $error("fast exit waited for the timer");
  run_start_a: assert property ( // [RULE_05]
    @(posedge pclk) disable iff (!presetn)
    go_run |=> core_run && restart_pc == RCS_VEC_RESET)
    else $error("ready clock did not start the core");
  pin_flags_a: assert property ( // [RULE_08]
    @(posedge pclk) disable iff (!presetn)
    evt.pin_rst && !in_sleep && !in_idle && !cause_wr |=>
      cause_q[RCS_B_EXTERNAL_RESET_FLAG] && !cause_q[RCS_B_SWRST] &&
      !cause_q[RCS_B_SLEEP])
    else $error("pin reset flags wrong");
  sw_flags_a: assert property ( // [RULE_09]
    @(posedge pclk) disable iff (!presetn)
    evt.sw_rst && !evt.pin_rst && !cause_wr |=>
      cause_q[RCS_B_SWRST] && !cause_q[RCS_B_EXTERNAL_RESET_FLAG])
    else $error("software reset flags wrong");
  sleep_pin_a: assert property ( // [RULE_10]
    @(posedge pclk) disable iff (!presetn)
    evt.pin_rst && in_sleep |=>
      cause_q[RCS_B_EXTERNAL_RESET_FLAG] && cause_q[RCS_B_SLEEP] &&
      !cause_q[RCS_B_WATCHDOG_TIMEOUT_FLAG] && !cause_q[RCS_B_IDLE])
    else $error("pin reset in sleep flags wrong");
  idle_pin_a: assert property ( // [RULE_11]
    @(posedge pclk) disable iff (!presetn)
    evt.pin_rst && !in_sleep && in_idle |=>
      cause_q[RCS_B_EXTERNAL_RESET_FLAG] && cause_q[RCS_B_IDLE] &&
      !cause_q[RCS_B_WATCHDOG_TIMEOUT_FLAG] && !cause_q[RCS_B_SLEEP])
    else $error("pin reset in idle flags wrong");
  wake_keep_a: assert property ( // [RULE_12]
    @(posedge pclk) disable iff (!presetn)
    evt.irq_wake && in_sleep && !evt.pin_rst && !evt.sw_rst &&
    !evt.wdt_to && !evt.trap_rst && !evt.illop_rst && !cause_wr |=>
      cause_q == ($past(cause_q) | bit1(RCS_B_SLEEP)))
    else $error("interrupt wake touched other flags");
  wake_vector_a: assert property ( // [RULE_13]
    @(posedge pclk) disable iff (!presetn)
    evt.irq_wake && evt.irq_vec_en && in_sleep && !evt.pin_rst &&
    !evt.sw_rst && !evt.wdt_to && !evt.trap_rst && !evt.illop_rst &&
    st_q == RCS_ST_RUN |=> restart_pc == $past(irq_vector))
    else $error("enabled wake did not load its vector");
  wdt_reset_a: assert property ( // [RULE_15]
    @(posedge pclk) disable iff (!presetn)
    evt.wdt_to && !in_sleep && !evt.pin_rst && !evt.sw_rst |=>
      cause_q[RCS_B_WATCHDOG_TIMEOUT_FLAG] && !cause_q[RCS_B_EXTERNAL_RESET_FLAG] &&
      !cause_q[RCS_B_SWRST] && !cause_q[RCS_B_SLEEP])
    else $error("watchdog reset flags wrong");
  trap_flag_a: assert property ( // [RULE_16]
    @(posedge pclk) disable iff (!presetn)
    evt.trap_rst && !evt.pin_rst && !evt.sw_rst && !evt.wdt_to |=>
      cause_q[RCS_B_TRAP])
    else $error("trap reset flag not set");
  flag_hold_a: assert property ( // [RULE_14]
    @(posedge pclk) disable iff (!presetn)
    !ev_any && !cause_wr |=> $stable(cause_q))
    else $error("cause flags changed without cause");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    |(ist_q & ien_q) && !(wr && a_iclr) |=> irq)
    else $error("interrupt not raised");
  cov_fail_c: cover property (@(posedge pclk) clk_fail);
  cov_frozen_c: cover property (@(posedge pclk)
    st_q == RCS_ST_FROZEN ##1 st_q == RCS_ST_RUN);
  cov_wake_c: cover property (@(posedge pclk) ev_wake);
  cov_fast_c: cover property (@(posedge pclk)
    st_q == RCS_ST_TIMER && put_bypass);
endmodule

/* rcs_far_model.sv */
// far-side model: crystal status and reset or wake event sources
// assumes the pclk domain; the bench asks for event pulses via fire
`timescale 1ns/1ps
module rcs_far_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench control: cycles until the crystal is usable
  input wire logic [15:0] osc_delay,
  // toward the block
  output rcs_pkg::rcs_evt_t evt,
  output rcs_pkg::rcs_osc_t osc
);
  import rcs_pkg::*;
  logic [15:0] age_q; // cycles since reset release
  logic ready_w; // crystal running, timed out and locked
  // crystal keeps its own schedule, not the reset timers
  assign ready_w = (age_q >= osc_delay);
  // pll is in use, so a slow lock also counts as not ready
  assign osc = '{ready_w, ready_w, ready_w, 1'b1};
  // saturating age, so an all-ones delay means the crystal never starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_q <= 16'h0000;
    end else if (age_q != 16'hFFFE) begin
      age_q <= age_q + 16'h0001;
    end
  end
  initial evt = '0;
  // one-cycle event pulse launched just after a rising edge
  task automatic fire(input logic [6:0] e);
    @(posedge pclk);
    evt <= rcs_evt_t'(e);
    @(posedge pclk);
    evt <= '0;
  endtask
endmodule

/* rcs_pkg.sv */
// package for the reset cause and start-up block
// assumes a 100 MHz pclk and an APB master with 32-bit data
package rcs_pkg;
  // register byte offsets
  localparam logic [7:0] RCS_OFF_CAUSE = 8'h00;
  localparam logic [7:0] RCS_OFF_CTRL = 8'h04;
  localparam logic [7:0] RCS_OFF_STAT = 8'h08;
  localparam logic [7:0] RCS_OFF_IRQ_ST = 8'h0C;
  localparam logic [7:0] RCS_OFF_IRQ_EN = 8'h10;
  localparam logic [7:0] RCS_OFF_IRQ_CLR = 8'h14;
  localparam logic [7:0] RCS_OFF_PC = 8'h18;
  // cause flag bit positions
  localparam int RCS_B_POR = 0;
  localparam int RCS_B_SLEEP = 1;
  localparam int RCS_B_IDLE = 2;
  localparam int RCS_B_WATCHDOG_TIMEOUT_FLAG = 3;
  localparam int RCS_B_SWRST = 4;
  localparam int RCS_B_EXTERNAL_RESET_FLAG = 5;
  localparam int RCS_B_IOP = 6;
  localparam int RCS_B_TRAP = 7;
  localparam int RCS_NFLAG = 8;
  // control bit positions
  localparam int RCS_C_CFM = 0;
  localparam int RCS_C_PUT = 1;
  localparam int RCS_C_SRC = 2;
  // interrupt event positions
  localparam int RCS_E_CLKFAIL = 0;
  localparam int RCS_E_RESET = 1;
  localparam int RCS_E_WAKE = 2;
  localparam int RCS_NEV = 3;
  // restart addresses
  localparam logic [23:0] RCS_VEC_RESET = 24'h000000;
  localparam logic [23:0] RCS_VEC_CLKFAIL = 24'h000004;
  localparam logic [23:0] RCS_PC_STEP = 24'h000002;
  // reset values
  localparam logic [7:0] RCS_CAUSE_RST = 8'h01;
  localparam logic [2:0] RCS_CTRL_RST = 3'h3;
  // start-up timer, in ns, and its cycle count
  localparam int RCS_CLK_NS = 10;
  localparam int RCS_PUT_NS = 64000;
  localparam int RCS_PUT_CYC = RCS_PUT_NS / RCS_CLK_NS;
  // clock source selection
  typedef enum logic [1:0] {
    RCS_SRC_FRC = 2'b00,
    RCS_SRC_EXT = 2'b01,
    RCS_SRC_XTAL = 2'b10
  } rcs_src_t;
  // start-up sequencer states
  typedef enum logic [1:0] {
    RCS_ST_TIMER = 2'b00,
    RCS_ST_CHECK = 2'b01,
    RCS_ST_FROZEN = 2'b10,
    RCS_ST_RUN = 2'b11
  } rcs_state_t;
  // reset and wake events, one cycle pulses
  typedef struct packed {
    logic pin_rst;
    logic sw_rst;
    logic wdt_to;
    logic irq_wake;
    logic irq_vec_en;
    logic trap_rst;
    logic illop_rst;
  } rcs_evt_t;
  // oscillator status inputs
  typedef struct packed {
    logic osc_running;
    logic ost_done;
    logic pll_lock;
    logic pll_used;
  } rcs_osc_t;
endpackage

/* rcs_put_timer.sv */
// power-up timer: counts a fixed interval after start
// assumes start is a one-cycle pulse in the pclk domain
`timescale 1ns/1ps
module rcs_put_timer #(
  parameter int CYCLES = rcs_pkg::RCS_PUT_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic start,
  input wire logic bypass,
  output logic done
);
  import rcs_pkg::*;
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_q; // cycles still to run
  logic running_q; // interval in progress
  wire last = (cnt_q == W'(1));
  // count down, bypass finishes at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      running_q <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      cnt_q <= W'(CYCLES);
      running_q <= !bypass;
      done <= bypass;
    end else if (running_q) begin
      // a bypass raised mid-count ends the interval at once
      cnt_q <= cnt_q - W'(1);
      running_q <= !last && !bypass;
      done <= last || bypass;
    end else begin
      done <= 1'b0;
    end
  end
endmodule

/* testbench.sv */
// self-checking bench for the reset cause and start-up block
// assumes rcs_core, the far-side model and a 100 MHz pclk
`timescale 1ns/1ps
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin \
  mismatches++; $display("CHECK FAILED %0t %s", $time, m); end end
module testbench;
  import rcs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic in_sleep, in_idle, core_run, restart_pulse, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] cur_pc, irq_vector, restart_pc;
  logic [15:0] osc_delay;
  rcs_evt_t evt;
  rcs_osc_t osc;
  rcs_src_t clk_src;
  int mismatches, total_checks;
  // event table: pulse, flags set, flags cleared
  logic [6:0] ev [10] = '{7'h40, 7'h20, 7'h40, 7'h40, 7'h10, 7'h10,
    7'h08, 7'h0C, 7'h02, 7'h01};
  logic [7:0] set_f [10] = '{8'h20, 8'h10, 8'h22, 8'h24, 8'h08, 8'h0A,
    8'h02, 8'h02, 8'h80, 8'h40};
  logic [7:0] clr_f [10] = '{8'h1E, 8'h2E, 8'h0C, 8'h0A, 8'h36, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00};
  // per row: asleep, idle, resume at pc plus two, resume at vector
  logic [9:0] slp_m = 10'h0E4;
  logic [9:0] idl_m = 10'h008;
  logic [9:0] p2_m = 10'h060;
  logic [9:0] vec_m = 10'h080;

  // design and far side
  rcs_core #(.PUT_CYCLES(8)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .evt(evt), .osc(osc), .in_sleep(in_sleep), .in_idle(in_idle),
    .cur_pc(cur_pc), .irq_vector(irq_vector), .core_run(core_run),
    .restart_pulse(restart_pulse), .restart_pc(restart_pc),
    .clk_src(clk_src), .irq(irq));
  rcs_far_model i_far (.pclk(pclk), .presetn(presetn),
    .osc_delay(osc_delay), .evt(evt), .osc(osc));

  // free-running 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // verdict and end of run
  task automatic stop_test();
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // an exhausted wait counts as a mismatch
  task automatic timeout();
    mismatches++;
    $display("CHECK FAILED %0t wait ran out", $time);
    stop_test();
  endtask

  // reset held ten cycles, crystal delay chosen per run
  task automatic do_reset(input logic [15:0] d);
    presetn <= 1'b0;
    osc_delay <= d;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    if (n == 20) timeout();
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // bounded wait on core_run (0) or restart_pulse (1)
  task automatic wait_for(input int which, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(posedge pclk);
      if ((which == 0 ? core_run : restart_pulse) === 1'b1) break;
    end
    if (n == lim) timeout();
  endtask

  // main sequence
  initial begin
    int i, k;
    logic [7:0] exp;
    logic [23:0] pc_exp;
    mismatches = 0;
    total_checks = 0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    in_sleep = 1'b0;
    in_idle = 1'b0;
    cur_pc = 24'h000120;
    irq_vector = 24'h000040;
    // crystal ready in time: plain start at zero
    do_reset(16'h0002);
    wait_for(0, 40);
    `CHK(restart_pc, RCS_VEC_RESET, "start pc")
    `CHK(clk_src, RCS_SRC_XTAL, "start source")
    apb(1'b0, RCS_OFF_CAUSE, 32'h0);
    `CHK(rd, 32'h00000001, "power-on cause")
    apb(1'b0, 8'h40, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0}, "unmapped read")
    // every event, over empty and over full flags
    for (k = 0; k < 2; k++) begin
      for (i = 0; i < 10; i++) begin
        exp = (k == 1) ? 8'hFF : 8'h00;
        apb(1'b1, RCS_OFF_CAUSE, {24'h0, exp});
        in_sleep <= slp_m[i];
        in_idle <= idl_m[i];
        i_far.fire(ev[i]);
        wait_for(1, 40);
        pc_exp = vec_m[i] ? irq_vector :
          (p2_m[i] ? cur_pc + RCS_PC_STEP : RCS_VEC_RESET);
        `CHK(restart_pc, pc_exp, "restart pc")
        exp = (exp & ~clr_f[i]) | set_f[i];
        in_sleep <= 1'b0;
        in_idle <= 1'b0;
        apb(1'b0, RCS_OFF_CAUSE, 32'h0);
        `CHK(rd[7:0], exp, "cause flags")
      end
    end
    // interrupt raised, masked, then cleared
    apb(1'b1, RCS_OFF_IRQ_CLR, 32'h7);
    apb(1'b1, RCS_OFF_IRQ_EN, 32'h2);
    apb(1'b0, RCS_OFF_IRQ_ST, 32'h0);
    `CHK(rd, 32'h0, "status cleared")
    i_far.fire(7'h20);
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b1, "irq raised")
    apb(1'b1, RCS_OFF_IRQ_EN, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0, "irq masked")
    apb(1'b1, RCS_OFF_IRQ_EN, 32'h2);
    apb(1'b1, RCS_OFF_IRQ_CLR, 32'h2);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0, "irq cleared")
    // no crystal, monitor on: fail vector on the rc clock
    do_reset(16'hFFFF);
    wait_for(0, 40);
    `CHK(restart_pc, RCS_VEC_CLKFAIL, "fail vector")
    `CHK(clk_src, RCS_SRC_FRC, "fail source")
    apb(1'b0, RCS_OFF_IRQ_ST, 32'h0);
    `CHK(rd[RCS_E_CLKFAIL], 1'b1, "fail status")
    apb(1'b0, RCS_OFF_CAUSE, 32'h0);
    `CHK(rd, 32'h00000001, "fail keeps flags")
    // monitor off, no crystal: held until the crystal starts
    do_reset(16'hFFFF);
    apb(1'b1, RCS_OFF_CTRL, 32'hA);
    repeat (30) @(posedge pclk);
    `CHK(core_run, 1'b0, "frozen")
    osc_delay <= 16'h0000;
    wait_for(0, 20);
    `CHK(restart_pc, RCS_VEC_RESET, "thawed pc")
    // monitor and timer off: start well before the timer would end
    do_reset(16'h0000);
    apb(1'b1, RCS_OFF_CTRL, 32'h0);
    wait_for(0, 5);
    `CHK(clk_src, RCS_SRC_FRC, "fast exit source")
    `CHK(restart_pc, RCS_VEC_RESET, "fast exit pc")
    stop_test();
  end
endmodule
